// >>> core/scg_pkg.sv
/*
  Constants, register map and types for the sleep-mode clock gating block.
  Assumes an AHB-Lite slave decode by hsel and a single system clock.
*/
// Summary of operation
// - set bit clocks its peripheral, clear disables it
// - access to a gated peripheral gives bus fault; here it raises accessFault, a status bit and, if its mask bit is set, irq, and hresp stays OKAY
// - reset clears every gating bit to zero
// - sleep register used only in sleep mode
// - sleep registers apply only with auto-select set
// - reserved bits are read-only and read zero
// - bits 26..24 gate comparators 2..0
// - bits 19..16 gate timers 3..0
// - bit 4 gates the synchronous serial port
// - bits 1 and 0 gate serial ports 1, 0
// - sleep gating register decoded at offset 0x114
`default_nettype none
package scg_pkg;

  // register byte offsets within the system control space
  localparam logic [11:0] SCG_OFF_RUN   = 12'h104;
  localparam logic [11:0] SCG_OFF_SLEEP = 12'h114;
  localparam logic [11:0] SCG_OFF_DEEP  = 12'h124;
  localparam logic [11:0] SCG_OFF_CFG   = 12'h160;
  localparam logic [11:0] SCG_OFF_STAT  = 12'h200;
  localparam logic [11:0] SCG_OFF_MASK  = 12'h204;

  // gating bit positions
  localparam int SCG_BIT_COMPARATOR2  = 26;
  localparam int SCG_BIT_COMPARATOR1  = 25;
  localparam int SCG_BIT_COMPARATOR0  = 24;
  localparam int SCG_BIT_GP_A         = 19;
  localparam int SCG_BIT_GP_B         = 18;
  localparam int SCG_BIT_GP_C         = 17;
  localparam int SCG_BIT_GP_D         = 16;
  localparam int SCG_BIT_SYNC_SERIAL0 = 4;
  localparam int SCG_BIT_SERIAL_PORT1 = 1;
  localparam int SCG_BIT_SERIAL_PORT0 = 0;

  // implemented gating bits, everything else reserved and read as zero
  localparam logic [31:0] SCG_GATE_IMPL = 32'(
    (64'h1 << SCG_BIT_COMPARATOR2) | (64'h1 << SCG_BIT_COMPARATOR1) | (64'h1 << SCG_BIT_COMPARATOR0) |
    (64'h1 << SCG_BIT_GP_A) | (64'h1 << SCG_BIT_GP_B) | (64'h1 << SCG_BIT_GP_C) | (64'h1 << SCG_BIT_GP_D) |
    (64'h1 << SCG_BIT_SYNC_SERIAL0) | (64'h1 << SCG_BIT_SERIAL_PORT1) | (64'h1 << SCG_BIT_SERIAL_PORT0));
  localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0000;

  // clock configuration register: auto sleep gating select
  localparam int          SCG_BIT_AUTO_SEL = 0;
  localparam logic [31:0] SCG_CFG_IMPL     = 32'h0000_0001;
  localparam logic [31:0] SCG_CFG_RESET    = 32'h0000_0000;

  // bus encodings
  localparam logic [2:0] SCG_HSIZE_WORD = 3'h2;
  localparam logic       SCG_HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {SCG_MODE_RUN, SCG_MODE_SLEEP, SCG_MODE_DEEP} scg_mode_type;

endpackage
`default_nettype wire

// >>> core/scg_gate_if.sv
/*
  Bundle between the register front end and the clock enable stage.
  Assumes both sides run on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
interface scg_gate_if;
  import scg_pkg::*;
  logic [31:0]  runGate;
  logic [31:0]  sleepGate;
  logic [31:0]  deepGate;
  logic         autoSel;
  scg_mode_type mode;
  logic [31:0]  clkEnable;

  modport ctrl (output runGate, output sleepGate, output deepGate, output autoSel, output mode,
                input clkEnable);
  modport gate (input runGate, input sleepGate, input deepGate, input autoSel, input mode,
                output clkEnable);
endinterface
`default_nettype wire

// >>> core/scg_clock_enable.sv
/*
  Clock enable stage: picks run, sleep or deep-sleep gating per power mode
  and registers one enable per peripheral.
  Assumes enables feed integrated clock gate cells downstream.
*/
`timescale 1ns/1ns
`default_nettype none
module scg_clock_enable
  import scg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  scg_gate_if.gate  gif
);

  logic [31:0] nxt_sel;

  // mode picks the source register
  always_comb begin
    nxt_sel = gif.runGate;
    case (gif.mode)
      SCG_MODE_SLEEP: begin
        if (gif.autoSel) begin
          nxt_sel = gif.sleepGate;
        end
      end
      SCG_MODE_DEEP: begin
        if (gif.autoSel) begin
          nxt_sel = gif.deepGate;
        end
      end
      default: begin
        nxt_sel = gif.runGate;
      end
    endcase
  end

  // one registered enable per bit, changes only at a clock edge
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_en
      logic en_ff;
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          en_ff <= SCG_GATE_RESET[i];
        end else begin
          en_ff <= nxt_sel[i] & SCG_GATE_IMPL[i];
        end
      end
      assign gif.clkEnable[i] = en_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> core/scg_sleep_clock_gate.sv
/*
  Sleep-mode clock gating control with run and deep-sleep companions,
  AHB-Lite register slave, peripheral access fault detection and interrupt.
  Assumes power mode inputs are asynchronous pins, periphAccess comes from
  the system bus decode on clk_sys, and hsel is driven by the bus decoder.
*/
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module scg_sleep_clock_gate
  import scg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        sleepMode,
  input  wire logic        deepSleepMode,
  input  wire logic [31:0] periphAccess,
  output var  logic [31:0] clkEnable,
  output var  logic [31:0] accessFault,
  output var  logic        irq
);

  scg_gate_if gif ();

  // bus state
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic        wrPend_ff;
  logic        rdPend_ff;
  logic [11:0] addr_ff;
  logic        accept;
  logic [31:0] rdValue;

  // registers
  logic [31:0] runGate_ff;
  logic [31:0] sleepGate_ff;
  logic [31:0] deepGate_ff;
  logic [31:0] cfg_ff;
  logic [31:0] stat_ff;
  logic [31:0] mask_ff;
  logic [31:0] nxt_stat;

  // power mode synchronisers and mode
  logic         slpMeta_ff;
  logic         slp_ff;
  logic         dslMeta_ff;
  logic         dsl_ff;
  scg_mode_type mode_ff;

  // fault and interrupt
  logic [31:0] faultEvt;
  logic [31:0] accessFault_ff;
  logic        irq_ff;

  // address phase taken when selected, active and bus ready
  assign accept = hsel && htrans[1] && hready;

  // pending data phase flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff   <= 12'h000;
    end else begin
      wrPend_ff <= accept && hwrite && (hsize == SCG_HSIZE_WORD);
      rdPend_ff <= accept && !hwrite;
      if (accept) begin
        addr_ff <= haddr[11:0];
      end
    end
  end

  // one wait state on reads so a preceding write is visible
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= !(accept && !hwrite);
    end
  end

  // read multiplexer, reserved bits and unmapped offsets read zero
  always_comb begin
    rdValue = 32'h0000_0000;
    case (addr_ff)
      SCG_OFF_RUN: begin
        rdValue = runGate_ff & SCG_GATE_IMPL;
      end
      SCG_OFF_SLEEP: begin
        rdValue = sleepGate_ff & SCG_GATE_IMPL;
      end
      SCG_OFF_DEEP: begin
        rdValue = deepGate_ff & SCG_GATE_IMPL;
      end
      SCG_OFF_CFG: begin
        rdValue = cfg_ff & SCG_CFG_IMPL;
      end
      SCG_OFF_STAT: begin
        rdValue = stat_ff & SCG_GATE_IMPL;
      end
      SCG_OFF_MASK: begin
        rdValue = mask_ff & SCG_GATE_IMPL;
      end
      default: begin
        rdValue = 32'h0000_0000;
      end
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rdPend_ff) begin
      hrdata_ff <= rdValue;
    end
  end

  // gating registers, writes keep only implemented bits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      runGate_ff   <= SCG_GATE_RESET;
      sleepGate_ff <= SCG_GATE_RESET;
      deepGate_ff  <= SCG_GATE_RESET;
    end else if (wrPend_ff) begin
      if (addr_ff == SCG_OFF_RUN) begin
        runGate_ff <= hwdata & SCG_GATE_IMPL;
      end
      if (addr_ff == SCG_OFF_SLEEP) begin
        sleepGate_ff <= hwdata & SCG_GATE_IMPL;
      end
      if (addr_ff == SCG_OFF_DEEP) begin
        deepGate_ff <= hwdata & SCG_GATE_IMPL;
      end
    end
  end

  // configuration and interrupt mask
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_ff  <= SCG_CFG_RESET;
      mask_ff <= 32'h0000_0000;
    end else if (wrPend_ff) begin
      if (addr_ff == SCG_OFF_CFG) begin
        cfg_ff <= hwdata & SCG_CFG_IMPL;
      end
      if (addr_ff == SCG_OFF_MASK) begin
        mask_ff <= hwdata & SCG_GATE_IMPL;
      end
    end
  end

  // access to an unclocked peripheral is a fault
  assign faultEvt = periphAccess & ~clkEnable & SCG_GATE_IMPL;

  // sticky status, write one clears, a new event wins over the clear
  always_comb begin
    nxt_stat = stat_ff;
    if (wrPend_ff && addr_ff == SCG_OFF_STAT) begin
      nxt_stat = stat_ff & ~hwdata;
    end
    nxt_stat = (nxt_stat | faultEvt) & SCG_GATE_IMPL;
  end

  // status and fault pulse registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_ff        <= 32'h0000_0000;
      accessFault_ff <= 32'h0000_0000;
    end else begin
      stat_ff        <= nxt_stat;
      accessFault_ff <= faultEvt;
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // two-stage synchronisers for the power mode pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slpMeta_ff <= 1'b0;
      slp_ff     <= 1'b0;
      dslMeta_ff <= 1'b0;
      dsl_ff     <= 1'b0;
    end else begin
      slpMeta_ff <= sleepMode;
      slp_ff     <= slpMeta_ff;
      dslMeta_ff <= deepSleepMode;
      dsl_ff     <= dslMeta_ff;
    end
  end

  // power mode, deep sleep takes precedence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_ff <= SCG_MODE_RUN;
    end else if (dsl_ff) begin
      mode_ff <= SCG_MODE_DEEP;
    end else if (slp_ff) begin
      mode_ff <= SCG_MODE_SLEEP;
    end else begin
      mode_ff <= SCG_MODE_RUN;
    end
  end

  // hand registers to the enable stage
  assign gif.runGate   = runGate_ff;
  assign gif.sleepGate = sleepGate_ff;
  assign gif.deepGate  = deepGate_ff;
  assign gif.autoSel   = cfg_ff[SCG_BIT_AUTO_SEL];
  assign gif.mode      = mode_ff;

  // registered enables, glitch free by construction
  scg_clock_enable u_enable (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .gif     (gif.gate)
  );

  // outputs
  assign hreadyout   = hreadyout_ff;
  assign hresp       = SCG_HRESP_OKAY;
  assign hrdata      = hrdata_ff;
  assign clkEnable   = gif.clkEnable;
  assign accessFault = accessFault_ff;
  assign irq         = irq_ff;

  // reset leaves every peripheral unclocked
  property p_reset_clear;
    @(posedge clk_sys) $rose(rst_n) |-> (sleepGate_ff == SCG_GATE_RESET) && (clkEnable == SCG_GATE_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("gating not cleared by reset");

  // sleep register write lands masked
  property p_sleep_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (wrPend_ff && addr_ff == SCG_OFF_SLEEP) |=> (sleepGate_ff == ($past(hwdata) & SCG_GATE_IMPL));
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("sleep gate write lost");

  // reserved bits of gating registers read zero
  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (rdPend_ff && (addr_ff == SCG_OFF_SLEEP || addr_ff == SCG_OFF_RUN || addr_ff == SCG_OFF_DEEP))
      |=> ((hrdata & ~SCG_GATE_IMPL) == 32'h0000_0000) && hreadyout;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero");

  // sleep mode with auto select follows the sleep register
  property p_sleep_apply;
    @(posedge clk_sys) disable iff (!rst_n)
      (mode_ff == SCG_MODE_SLEEP && gif.autoSel) |=> (clkEnable == $past(sleepGate_ff));
  endproperty
  a_sleep_apply: assert property (p_sleep_apply) else $error("sleep gating not applied");

  // deep sleep with auto select follows the deep register
  property p_deep_apply;
    @(posedge clk_sys) disable iff (!rst_n)
      (mode_ff == SCG_MODE_DEEP && gif.autoSel) |=> (clkEnable == $past(deepGate_ff));
  endproperty
  a_deep_apply: assert property (p_deep_apply) else $error("deep gating not applied");

  // without auto select the run register always applies
  property p_run_fallback;
    @(posedge clk_sys) disable iff (!rst_n)
      !gif.autoSel |=> (clkEnable == $past(runGate_ff));
  endproperty
  a_run_fallback: assert property (p_run_fallback) else $error("run gating not applied");

  // access to gated unit reports a fault next cycle
  property p_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (accessFault == ($past(periphAccess) & ~$past(clkEnable) & SCG_GATE_IMPL));
  endproperty
  a_fault: assert property (p_fault) else $error("fault pulse mismatch");

  // a clocked unit never faults
  property p_clocked_no_fault;
    @(posedge clk_sys) disable iff (!rst_n)
      ((periphAccess & ~clkEnable) == 32'h0000_0000) |=> (accessFault == 32'h0000_0000);
  endproperty
  a_clocked_no_fault: assert property (p_clocked_no_fault) else $error("fault on clocked unit");

  // enables only move when a source or the mode moved
  property p_no_glitch;
    @(posedge clk_sys) disable iff (!rst_n)
      ($stable(runGate_ff) && $stable(sleepGate_ff) && $stable(deepGate_ff) && $stable(mode_ff)
       && $stable(gif.autoSel)) |=> $stable(clkEnable);
  endproperty
  a_no_glitch: assert property (p_no_glitch) else $error("enable changed without cause");

  // comparator 2 bit follows bit 26 in sleep
  property p_comparator2_map;
    @(posedge clk_sys) disable iff (!rst_n)
      (mode_ff == SCG_MODE_SLEEP && gif.autoSel) |=> (clkEnable[SCG_BIT_COMPARATOR2] == $past(sleepGate_ff[26]));
  endproperty
  a_comparator2_map: assert property (p_comparator2_map) else $error("comparator 2 enable mismapped");

  // read answers after exactly one wait cycle
  property p_read_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  // interrupt follows unmasked status
  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      ((stat_ff & mask_ff) != 32'h0000_0000) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  // a fault event sets its status bit, also against a clear in that cycle
  property p_status_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (faultEvt != 32'h0000_0000) |=> ((stat_ff & $past(faultEvt)) == $past(faultEvt));
  endproperty
  a_status_set: assert property (p_status_set) else $error("fault status not set");

  // interrupt stays low while no unmasked status bit is set
  property p_irq_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      ((stat_ff & mask_ff) == 32'h0000_0000) |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without status");

  // deep sleep pin wins over the sleep pin
  property p_deep_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      dsl_ff |=> (mode_ff == SCG_MODE_DEEP);
  endproperty
  a_deep_wins: assert property (p_deep_wins) else $error("deep sleep not taken");

endmodule
`default_nettype wire

// >>> verif/scg_sleep_clock_gate_bench.sv
/*
  Self-checking bench for the sleep-mode clock gating block.
  Assumes the design package, interface and modules are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module scg_sleep_clock_gate_bench
  import scg_pkg::*;
();
  // implemented gating bits, worked out from the bit list
  localparam logic [31:0] IMPL = 32'h070F_0013;
  localparam logic [11:0] OFFS [6] = '{SCG_OFF_RUN, SCG_OFF_SLEEP, SCG_OFF_DEEP,
                                       SCG_OFF_CFG, SCG_OFF_STAT, SCG_OFF_MASK};
  localparam int          BITS [10] = '{26, 25, 24, 19, 18, 17, 16, 4, 1, 0};

  logic        clk_sys       = 1'b0;
  logic        rst_n         = 1'b0;
  logic        hsel          = 1'b0;
  logic        hwrite        = 1'b0;
  logic [1:0]  htrans        = 2'b00;
  logic [2:0]  hsize         = SCG_HSIZE_WORD;
  logic [31:0] haddr         = 32'h0000_0000;
  logic [31:0] hwdata        = 32'h0000_0000;
  logic [31:0] periphAccess  = 32'h0000_0000;
  logic        sleepMode     = 1'b0;
  logic        deepSleepMode = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] hrdata;
  logic [31:0] clkEnable;
  logic [31:0] accessFault;
  int          error_cnt     = 0;
  int          checks        = 0;
  logic [31:0] rg [3];
  logic [31:0] st;
  logic [31:0] v;
  logic        autoE;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  scg_sleep_clock_gate DUT (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hreadyout),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .hrdata        (hrdata),
    .sleepMode     (sleepMode),
    .deepSleepMode (deepSleepMode),
    .periphAccess  (periphAccess),
    .clkEnable     (clkEnable),
    .accessFault   (accessFault),
    .irq           (irq)
  );

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // wait for hready sampled high at a rising edge; the watchdog bounds a hang
  task automatic wait_rdy;
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz,
                     output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= sz;
    wait_rdy;
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
    chk("hresp", {31'h0, SCG_HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, SCG_HSIZE_WORD, q);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, SCG_HSIZE_WORD, q);
    chk(nm, exp, q);
  endtask

  // expected enables from power mode and select bit
  function automatic logic [31:0] exp_en(input logic s, input logic d);
    if (autoE && d) return rg[2];
    if (autoE && s) return rg[1];
    return rg[0];
  endfunction

  // change power mode pins and check enables after the sync delay
  task automatic settle(input logic s, input logic d);
    @(posedge clk_sys);
    sleepMode     <= s;
    deepSleepMode <= d;
    repeat (6) @(posedge clk_sys);
    #1 chk("clkEnable", exp_en(s, d), clkEnable);
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #200_000;
    error_cnt++;
    $display("BAD watchdog expected done seen timeout");
    tally_and_finish;
  end

  // main sequence
  initial begin
    void'($urandom(32'h0d66));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (OFFS[i]) rd_chk("reset value", OFFS[i], 32'h0000_0000);
    chk("clkEnable", 32'h0000_0000, clkEnable);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    $display("test reset done");

    // readback with reserved bits, neighbour-offset and unmapped accesses
    for (int i = 0; i < 9; i++) begin
      v = (i < 3) ? 32'hFFFF_FFFF : $urandom;
      wr(OFFS[i % 3], v);
      rg[i % 3] = v & IMPL;
      rd_chk("gate register", OFFS[i % 3], rg[i % 3]);
    end
    wr(SCG_OFF_SLEEP + 12'h004, 32'h0000_0000);
    rd_chk("after neighbour write", SCG_OFF_SLEEP, rg[1]);
    wr(12'h300, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h300, 32'h0000_0000);
    $display("test registers done");

    // enable source per power mode and select bit
    autoE = 1'b0;
    settle(1'b1, 1'b0);
    settle(1'b0, 1'b1);
    wr(SCG_OFF_CFG, 32'hFFFF_FFFF);
    autoE = 1'b1;
    rd_chk("config", SCG_OFF_CFG, 32'h0000_0001);
    settle(1'b0, 1'b0);
    settle(1'b1, 1'b0);
    settle(1'b0, 1'b1);
    settle(1'b1, 1'b1);
    settle(1'b1, 1'b0);
    foreach (BITS[i]) begin
      wr(SCG_OFF_SLEEP, 32'h0000_0001 << BITS[i]);
      repeat (2) @(posedge clk_sys);
      #1 chk("one gate bit", 32'h0000_0001 << BITS[i], clkEnable);
    end
    $display("test modes done");

    // faults on gated peripherals, status, mask and interrupt
    st = 32'h0000_0000;
    wr(SCG_OFF_MASK, IMPL);
    // last pass hits every unit with all clocks off
    for (int i = 0; i < 6; i++) begin
      rg[1] = (i == 5) ? 32'h0000_0000 : $urandom & IMPL;
      wr(SCG_OFF_SLEEP, rg[1]);
      repeat (2) @(posedge clk_sys);
      v = (i == 5) ? 32'hFFFF_FFFF : $urandom;
      periphAccess <= v;
      @(posedge clk_sys);
      periphAccess <= 32'h0000_0000;
      #1 chk("accessFault", v & ~rg[1] & IMPL, accessFault);
      st = st | (v & ~rg[1] & IMPL);
      @(posedge clk_sys);
      #1 chk("fault pulse end", 32'h0000_0000, accessFault);
      rd_chk("status", SCG_OFF_STAT, st);
      chk("irq", {31'h0, |st}, {31'h0, irq});
    end
    wr(SCG_OFF_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(SCG_OFF_MASK, IMPL);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    wr(SCG_OFF_STAT, st);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rd_chk("status cleared", SCG_OFF_STAT, 32'h0000_0000);
    $display("test faults done");

    // reset in mid-run returns registers and enables to zero
    wr(SCG_OFF_SLEEP, IMPL);
    repeat (2) @(posedge clk_sys);
    #1 chk("clkEnable", IMPL, clkEnable);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (OFFS[i]) rd_chk("reset value", OFFS[i], 32'h0000_0000);
    #1 chk("clkEnable", 32'h0000_0000, clkEnable);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    $display("test mid reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
